// file: pkg/tmp_defs.svh
// Constants of the timing and management packet generator.
`ifndef TMP_DEFS_SVH
`define TMP_DEFS_SVH
`define RTP_BYTE0 8'h80
`define RTP_PTYPE 7'h4e
`define RTP_SSRC 32'h0000_0000
`define SEQ_INIT 16'h0000
`define DEST_IP 32'hef00_3330
`define DEST_PORT 16'h7571
`define STRUCT_RSV 10'h3ff
`define TX_RSV 31'h7fff_ffff
`define ERR_RSV 16'hffff
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hffff
`define HDR_LAST 4'hb
`define ENTRY_LAST 4'h7
`define ERR_LAST 4'h3
`define CRC_HI 4'h1
`define FIXED_BYTES 16'h000e
`define OVR_NORMAL 3'h0
`define OVR_FORCE 3'h7
`endif

// file: pkg/tmp_pkg.sv
// Types shared by the timing and management packet generator.
package tmp_pkg;
  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] ns;
  } emit_time_t;
  typedef struct packed {
    logic [12:0] transmitter_address;
    logic [15:0] time_offset;
    logic [3:0] inject_lvl;
  } tx_entry_t;
  typedef struct packed {
    logic [3:0] ver_major;
    logic [3:0] ver_minor;
    logic [3:0] rep_pre;
    logic [3:0] rep_tim;
    logic [3:0] bs_major;
    logic [3:0] bs_minor;
    logic [4:0] next_frame_gap_code;
    logic [1:0] bandwidth;
    logic [6:0] bsr_coef;
    logic [7:0] pre_struct;
    logic [1:0] wakeup;
    logic [5:0] emit_count;
    logic [2:0] override;
    logic [5:0] group_size;
    logic [12:0] tx_total;
  } frame_cfg_t;
  typedef struct packed {
    logic [7:0] data;
    logic sop;
    logic eop;
  } out_byte_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_STRU = 3'b010,
    ST_EMIT = 3'b011,
    ST_TX = 3'b100,
    ST_ERR = 3'b101
  } gen_state_t;
endpackage

// file: core/tmp_gen.sv
// Timing and management packet generator with a two-entry output buffer.
`timescale 1ns/1ns
`include "tmp_defs.svh"
module tmp_gen
  import tmp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire frame_cfg_t cfg_i,
  input wire emit_time_t now_i,
  input wire emit_time_t deadline_i,
  input wire logic emit_wr_i,
  input wire logic [5:0] emit_addr_i,
  input wire emit_time_t emit_data_i,
  input wire logic tx_wr_i,
  input wire logic [12:0] tx_addr_i,
  input wire tx_entry_t tx_data_i,
  input wire logic out_ready_i,
  output logic out_valid_o,
  output out_byte_t out_o,
  output logic [31:0] dest_ip_o,
  output logic [15:0] dest_port_o,
  output logic busy_o,
  output logic done_o,
  output logic late_o,
  output logic cfg_err_o
);
  emit_time_t emit_mem [0:63];
  tx_entry_t tx_mem [0:8191];
  gen_state_t st_q;
  frame_cfg_t cfg_q;
  logic [95:0] shift_q;
  logic [3:0] bcnt_q;
  logic [5:0] eidx_q;
  logic [12:0] tidx_q;
  logic [12:0] tx_left_q;
  logic [5:0] ng_q;
  logic [5:0] gcnt_q;
  logic [6:0] grp_q;
  logic [15:0] seq_q;
  logic [31:0] ts_q;
  logic [15:0] crc_q;
  out_byte_t buf_q [0:1];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  // Set while a packet header waits to be loaded into the shifter.
  // A flag is used because a zero shifter cannot tell the header load
  // apart from the last header byte, whose source identifier is zero.
  logic hdr_pend_q;

  // Only the five odd counts 1 to 9 are legal for majority voting.
  function automatic logic rep_ok(input logic [3:0] r);
    rep_ok = (r == 4'h1) || (r == 4'h3) || (r == 4'h5) || (r == 4'h7) ||
             (r == 4'h9);
  endfunction

  // Bitwise CRC-16 update for one payload byte, most significant bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    crc_byte = r;
  endfunction

  // Table writes; software must leave the tables alone while busy_o is high.
  always_ff @(posedge clock_i) begin
    if (emit_wr_i) begin
      emit_mem[emit_addr_i] <= emit_data_i;
    end
    if (tx_wr_i) begin
      tx_mem[tx_addr_i] <= tx_data_i;
    end
  end

  // Start checks and packet-level decode.
  wire cfg_ok = rep_ok(cfg_i.rep_pre) && rep_ok(cfg_i.rep_tim) &&
    (cfg_i.override == `OVR_NORMAL || cfg_i.override == `OVR_FORCE) &&
    (cfg_i.tx_total == 13'h0000 || cfg_i.group_size != 6'h00);
  wire start_go = start_i && (st_q == ST_IDLE) && cfg_ok;
  wire start_bad = start_i && (st_q == ST_IDLE) && !cfg_ok;
  wire in_ready = (cnt_q != 2'h2);
  // The header load cycle pushes nothing, which gives one idle slot.
  wire fire = (st_q != ST_IDLE) && in_ready && !hdr_pend_q;
  wire last_byte = (bcnt_q == 4'h0);
  wire [12:0] gsize = {7'h00, cfg_q.group_size};
  // A group never exceeds 63 entries, so the payload stays near 1032 bytes.
  wire [5:0] ng_next = (tx_left_q < gsize) ? tx_left_q[5:0] :
                       cfg_q.group_size;
  // The length counts the bytes after itself, so this packet's own
  // group size is used, not the size of the group still to come.
  wire [15:0] pay_len = `FIXED_BYTES + {7'h00, cfg_q.emit_count, 3'h0} +
                        16'h0008 + {7'h00, ng_q, 3'h0};
  wire emit_time_t ts_src = emit_mem[6'h00];
  wire emit_time_t emit_next = emit_mem[eidx_q + 6'h01];
  wire tx_entry_t tx_cur = tx_mem[tidx_q];
  wire tx_entry_t tx_next = tx_mem[tidx_q + 13'h0001];
  wire [63:0] emit_first_w = emit_mem[6'h00];

  // RTP fixed header: V=2, P=0, X=0, CC=0, M=0, zero source identifier.
  wire [95:0] hdr_w = {`RTP_BYTE0, 1'b0, `RTP_PTYPE, seq_q, ts_q,
                       `RTP_SSRC};
  wire [95:0] struct_w = {pay_len, cfg_q.ver_major, cfg_q.ver_minor,
    cfg_q.rep_pre, cfg_q.rep_tim, cfg_q.bs_major, cfg_q.bs_minor,
    cfg_q.next_frame_gap_code, cfg_q.bandwidth, cfg_q.bsr_coef,
    cfg_q.pre_struct, cfg_q.wakeup, cfg_q.emit_count, ng_q, grp_q,
    cfg_q.override, `STRUCT_RSV};
  wire [95:0] tx_first_w = {tx_cur, `TX_RSV, 32'h0000_0000};
  wire [95:0] tx_next_w = {tx_next, `TX_RSV, 32'h0000_0000};
  wire [95:0] err_w = {`ERR_RSV, 80'h0};

  // The check word bytes come straight from the running CRC.
  wire crc_slot = (st_q == ST_ERR) && (bcnt_q <= `CRC_HI);
  wire [7:0] cur_byte = !crc_slot ? shift_q[95:88] :
                        (bcnt_q == `CRC_HI) ? crc_q[15:8] : crc_q[7:0];
  wire pay_byte = (st_q != ST_HDR) && !crc_slot;
  wire pkt_last = (st_q == ST_ERR) && last_byte;
  wire frame_end = fire && pkt_last && (tx_left_q == 13'h0000);

  // Packet sequencer: one byte per cycle whenever the buffer has room, except in the header load cycle.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cfg_q <= '0;
      shift_q <= 96'h0;
      bcnt_q <= 4'h0;
      eidx_q <= 6'h00;
      tidx_q <= 13'h0000;
      tx_left_q <= 13'h0000;
      ng_q <= 6'h00;
      gcnt_q <= 6'h00;
      grp_q <= 7'h00;
      seq_q <= `SEQ_INIT;
      ts_q <= 32'h0000_0000;
      hdr_pend_q <= 1'b0;
    end else if (start_go) begin
      st_q <= ST_HDR;
      hdr_pend_q <= 1'b1;
      cfg_q <= cfg_i;
      tx_left_q <= cfg_i.tx_total;
      tidx_q <= 13'h0000;
      grp_q <= 7'h00;
      bcnt_q <= 4'h0;
      ts_q <= {ts_src.sec[21:0], ts_src.ns[29:20]};
    end else if (fire) begin
      shift_q <= {shift_q[87:0], 8'h00};
      bcnt_q <= bcnt_q - 4'h1;
      if (last_byte) begin
        unique case (st_q)
          ST_HDR: begin
            st_q <= ST_STRU;
            shift_q <= struct_w;
            bcnt_q <= `HDR_LAST;
          end
          ST_STRU: begin
            st_q <= ST_EMIT;
            eidx_q <= 6'h00;
            shift_q <= {emit_first_w, 32'h0000_0000};
            bcnt_q <= `ENTRY_LAST;
          end
          ST_EMIT: begin
            bcnt_q <= `ENTRY_LAST;
            if (eidx_q != cfg_q.emit_count) begin
              eidx_q <= eidx_q + 6'h01;
              shift_q <= {emit_next, 32'h0000_0000};
            end else if (ng_q != 6'h00) begin
              st_q <= ST_TX;
              gcnt_q <= ng_q - 6'h01;
              shift_q <= tx_first_w;
            end else begin
              st_q <= ST_ERR;
              shift_q <= err_w;
              bcnt_q <= `ERR_LAST;
            end
          end
          ST_TX: begin
            tidx_q <= tidx_q + 13'h0001;
            bcnt_q <= `ENTRY_LAST;
            if (gcnt_q != 6'h00) begin
              gcnt_q <= gcnt_q - 6'h01;
              shift_q <= tx_next_w;
            end else begin
              st_q <= ST_ERR;
              shift_q <= err_w;
              bcnt_q <= `ERR_LAST;
            end
          end
          ST_ERR: begin
            seq_q <= seq_q + 16'h0001;
            grp_q <= grp_q + 7'h01;
            st_q <= (tx_left_q == 13'h0000) ? ST_IDLE : ST_HDR;
            hdr_pend_q <= (tx_left_q != 13'h0000);
            bcnt_q <= 4'h0;
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
    // Header entry: load the RTP header and size this packet's group.
    if (!rst_i && hdr_pend_q && !start_go) begin
      hdr_pend_q <= 1'b0;
      shift_q <= hdr_w;
      bcnt_q <= `HDR_LAST;
      ng_q <= ng_next;
      tx_left_q <= tx_left_q - {7'h00, ng_next};
    end
  end

  // Running check word, restarted at each header.
  always_ff @(posedge clock_i) begin
    if (rst_i || st_q == ST_HDR) begin
      crc_q <= `CRC_INIT;
    end else if (fire && pay_byte) begin
      crc_q <= crc_byte(crc_q, cur_byte);
    end
  end

  // Two-entry buffer; a stalled receiver holds back the sequencer.
  wire buf_push = fire;
  wire buf_pop = (cnt_q != 2'h0) && out_ready_i;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_q[wr_ptr_q] <= '{data: cur_byte,
                             sop: st_q == ST_HDR && bcnt_q == `HDR_LAST,
                             eop: pkt_last};
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (buf_pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_o = buf_q[rd_ptr_q];

  // Busy flag, status pulses and fixed destination.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      late_o <= 1'b0;
      cfg_err_o <= 1'b0;
      dest_ip_o <= 32'h0000_0000;
      dest_port_o <= 16'h0000;
    end else begin
      busy_o <= start_go || (busy_o && !frame_end);
      done_o <= frame_end;
      late_o <= frame_end && (now_i > deadline_i);
      cfg_err_o <= start_bad;
      dest_ip_o <= `DEST_IP;
      dest_port_o <= `DEST_PORT;
    end
  end
endmodule

// file: bench/tmp_gen_monitor.sv
// Port checker for the timing and management packet generator.
`timescale 1ns/1ns
module tmp_gen_monitor
  import tmp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire emit_time_t now_i,
  input wire emit_time_t deadline_i,
  input wire logic out_ready_i,
  input wire logic out_valid_o,
  input wire out_byte_t out_o,
  input wire logic [31:0] dest_ip_o,
  input wire logic [15:0] dest_port_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic late_o,
  input wire logic cfg_err_o
);
  logic [15:0] pos_q;
  logic [15:0] pos_d;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Byte index in the packet, so header bytes can be checked by place.
  assign pos_d = out_o.eop ? 16'h0 : pos_q + 16'h1;
  always_ff @(posedge clock_i) begin
    if (rst_i)
      pos_q <= 16'h0;
    else if (out_valid_o && out_ready_i)
      pos_q <= pos_d;
  end
  // End of a frame takes one cycle, then status falls quiet.
  sequence s_close;
    done_o && !busy_o;
  endsequence
  sequence s_quiet;
    !done_o && !late_o;
  endsequence
  a_dest_const: assert property (
    !$past(rst_i) |-> dest_ip_o == 32'hef003330 && dest_port_o == 16'h7571)
    else $error("destination constants wrong");
  a_done_end: assert property (
    done_o |-> s_close ##1 s_quiet) else $error("done pulse malformed");
  a_late_cause: assert property (
    done_o |-> late_o == ($past(now_i) > $past(deadline_i)))
    else $error("late flag does not match times");
  a_late_done: assert property (late_o |-> done_o)
    else $error("late without done");
  a_start_go: assert property (
    start_i && !busy_o |-> ##[1:2] (busy_o || cfg_err_o))
    else $error("start neither taken nor refused");
  a_refuse_idle: assert property (
    cfg_err_o |-> !busy_o ##1 !busy_o) else $error("refused start ran");
  a_stall_hold: assert property (
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o))
    else $error("byte lost in stall");
  a_sop_place: assert property (
    out_valid_o |-> out_o.sop == (pos_q == 16'h0))
    else $error("start flag misplaced");
  a_rtp_byte0: assert property (
    out_valid_o && pos_q == 16'h0 |-> out_o.data == 8'h80)
    else $error("first header byte wrong");
  a_ptype_byte: assert property (
    out_valid_o && pos_q == 16'h1 |-> out_o.data == 8'h4e)
    else $error("payload type byte wrong");
  a_ssrc_zero: assert property (
    out_valid_o && pos_q >= 16'h8 && pos_q <= 16'hb |-> out_o.data == 8'h0)
    else $error("source identifier not zero");
  a_size_cap: assert property (out_valid_o |-> pos_q < 16'h5c0)
    else $error("packet too long");
endmodule
bind tmp_gen tmp_gen_monitor i_tmp_gen_monitor (.*);

// file: bench/tmp_sink.sv
// Byte sink standing in for the transmitter input logic.
`timescale 1ns/1ns
module tmp_sink (
  input wire logic clock_i,
  input wire logic [1:0] mode_i,
  output logic ready_o
);
  int seed = 32'haa0b828f;
  // Bytes are only taken as control input, never passed on.
  // Mode 1 stalls at random; mode 2 stalls hard so the buffer fills.
  always @(posedge clock_i) begin
    case (mode_i)
      2'h0: ready_o <= 1'b1;
      2'h1: ready_o <= ($random(seed) % 3) != 0;
      default: ready_o <= 1'b0;
    endcase
  end
  initial ready_o = 1'b0;
endmodule

// file: bench/tmp_gen_test.sv
// Self-checking bench for the timing and management packet generator.
`timescale 1ns/1ns
module tmp_gen_test;
  import tmp_pkg::*;
  logic clock_i = 1'b0, rst_i = 1'b1, start_i = 1'b0;
  logic emit_wr_i = 1'b0, tx_wr_i = 1'b0;
  logic [5:0] emit_addr_i = 6'h0;
  logic [12:0] tx_addr_i = 13'h0;
  frame_cfg_t cfg_i = '0, c;
  emit_time_t now_i = '0, deadline_i = '0, emit_data_i = '0;
  tx_entry_t tx_data_i = '0;
  logic out_ready_i, out_valid_o, busy_o, done_o, late_o, cfg_err_o;
  out_byte_t out_o;
  logic [31:0] dest_ip_o;
  logic [15:0] dest_port_o;
  logic [1:0] mode = 2'h1;
  logic [3:0] reps[5] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h9};
  int seed = 32'haa0b828f, errors = 0, n_checks = 0, cyc = 0, seq = 0;
  emit_time_t et[64];
  tx_entry_t tt[16];
  logic [9:0] exp[$];
  logic [7:0] b[$];
  tmp_gen i_tmp_gen (.*);
  tmp_sink i_tmp_sink (.clock_i(clock_i), .mode_i(mode), .ready_o(out_ready_i));
  always #5 clock_i = ~clock_i;
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // A hang counts as a mismatch and closes the run.
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      end_sim;
    end
  end
  // Every byte taken by the sink is compared with the model stream.
  always @(posedge clock_i) begin
    if (!rst_i && out_valid_o && out_ready_i) begin
      if (exp.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk(out_o, exp.pop_front());
    end
  end
  task automatic put(input logic [79:0] v, input int nb);
    for (int i = nb - 1; i >= 0; i--)
      b.push_back(v[i*8 +: 8]);
  endtask
  function automatic logic [15:0] crc(input logic [15:0] r, logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h1021 : 16'h0);
    return r;
  endfunction
  // Model of one frame: groups of transmitters, one packet per group.
  task automatic build(input frame_cfg_t f);
    int rem, n, g, k;
    logic [15:0] cr;
    logic [95:0] h;
    rem = f.tx_total;
    g = 0;
    k = 0;
    do begin
      n = rem < f.group_size ? rem : f.group_size;
      b = {};
      put(16'(14 + (f.emit_count + 1) * 8 + n * 8), 2);
      put({f[75:22], 6'(n), 7'(g), f.override, 10'h3ff}, 10);
      for (int i = 0; i <= f.emit_count; i++)
        put(et[i], 8);
      repeat (n) begin
        put({tt[k], 31'h7fffffff}, 8);
        k++;
      end
      put(16'hffff, 2);
      cr = 16'hffff;
      foreach (b[i]) cr = crc(cr, b[i]);
      put(cr, 2);
      h = {16'h804e, 16'(seq), et[0].sec[21:0], et[0].ns[29:20], 32'h0};
      for (int i = 11; i >= 0; i--)
        exp.push_back({h[i*8 +: 8], i == 11, 1'b0});
      foreach (b[i]) exp.push_back({b[i], 1'b0, i == b.size() - 1});
      seq++;
      g++;
      rem -= n;
    end while (rem > 0);
  endtask
  function automatic frame_cfg_t rnd(input int i);
    frame_cfg_t f;
    f = {$random(seed), $random(seed), $random(seed)};
    f.rep_pre = reps[i % 5];
    f.rep_tim = reps[(i + 2) % 5];
    f.override = i[0] ? 3'h7 : 3'h0;
    f.emit_count = 6'($unsigned($random(seed)) % 4);
    f.tx_total = 13'($unsigned($random(seed)) % 16);
    f.group_size = 6'(1 + $unsigned($random(seed)) % 5);
    return f;
  endfunction
  task automatic frame(input frame_cfg_t f, input bit bad, lt);
    int t;
    if (!bad)
      build(f);
    deadline_i <= lt ? '0 : '1;
    now_i <= {32'h1, 32'h0};
    @(posedge clock_i);
    start_i <= 1'b1;
    cfg_i <= f;
    @(posedge clock_i);
    start_i <= 1'b0;
    t = 0;
    while ((bad ? cfg_err_o : done_o) !== 1'b1 && t < 3000) begin
      @(posedge clock_i);
      t++;
    end
    chk(t < 3000, 1);
    if (!bad)
      chk(late_o, lt);
  endtask
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    seq = 0;
  endtask
  task automatic drain;
    for (int t = 0; t < 3000 && exp.size() > 0; t++)
      @(posedge clock_i);
    chk(exp.size(), 0);
  endtask
  // Tables are loaded while idle; only the first sixteen senders are used.
  task automatic fill;
    for (int i = 0; i < 64; i++) begin
      @(posedge clock_i);
      et[i] = {$random(seed), $random(seed)};
      if (i < 16)
        tt[i] = 33'($random(seed));
      emit_wr_i <= 1'b1;
      emit_addr_i <= 6'(i);
      emit_data_i <= et[i];
      tx_wr_i <= i < 16;
      tx_addr_i <= 13'(i);
      tx_data_i <= tt[i % 16];
    end
    @(posedge clock_i);
    emit_wr_i <= 1'b0;
    tx_wr_i <= 1'b0;
  endtask
  initial begin
    do_reset;
    chk(dest_ip_o, 32'hef003330);
    chk(dest_port_o, 16'h7571);
    fill;
    for (int i = 0; i < 10; i++)
      frame(rnd(i), 0, i == 3);
    c = rnd(4);
    c.emit_count = 6'h3f;
    c.tx_total = 13'h0;
    frame(c, 0, 0);
    // Refused configurations must send nothing at all.
    for (int i = 0; i < 3; i++) begin
      c = rnd(0);
      c.tx_total = 13'h5;
      if (i == 0)
        c.rep_tim = 4'h4;
      if (i == 1)
        c.override = 3'h3;
      if (i == 2)
        c.group_size = 6'h0;
      frame(c, 1, 0);
    end
    // Hard stall fills the two-entry buffer before the sink resumes.
    mode = 2'h2;
    fork
      frame(rnd(5), 0, 0);
      begin
        repeat (40) @(posedge clock_i);
        mode <= 2'h1;
      end
    join
    drain;
    do_reset;
    frame(rnd(6), 0, 0);
    drain;
    end_sim;
  end
endmodule
